//--- ieg_params.svh
// constants for the interrupt enable gating stage
// assumes inclusion by the package and the design modules by bare name
//
// Notes on behaviour
// - while the global enable is 0 no source reaches the core whatever its own enable holds.
// - a flag raised while the global enable is 0 stays pending and is presented once it is 1 again.
// - with the global enable at 1 a source requests only if its own enable bit is set too.
// - every flag that can interrupt can also be set to 1 by a software write.
// - an enabled interrupt is raised whenever its flag is 1, whether hardware or software set it.
// - main enable bit 6 gates the adc flag, bit 5 brown-out, bit 4 serial port 0 tx or rx.
// - main enable bit 3 gates timer 1, bit 2 external 1, bit 1 timer 0, bit 0 external 0.
// - ext a bit 7 gates timer 2, bit 6 spi (done, overrun or mode fault), bit 5 brake, bit 4 watchdog.
// - ext a bit 3 gates pwm, bit 2 any capture flag, bit 1 any pin flag, bit 0 i2c status or timeout.
// - ext b bit 2 gates wake timer, bit 1 timer 3, bit 0 serial port 1; bits 7 to 3 unused.
// - the ext a enable register resets to all zeros.
`ifndef IEG_PARAMS_SVH
`define IEG_PARAMS_SVH

// ****************************************
// register map (word index; the byte address on the bus is four times the index)
// ****************************************
`define IEG_IDX_EXT_A 8'h9b
`define IEG_IDX_EXT_B 8'h9c
`define IEG_IDX_MAIN 8'ha8
`define IEG_IDX_FLAG_LO 8'hb0
`define IEG_IDX_FLAG_HI 8'hb4
`define IEG_IDX_REQ 8'hb8

// ****************************************
// reset values and field layout
// ****************************************
`define IEG_RST_EXT_A 8'h00
`define IEG_RST_EXT_B 8'h00
`define IEG_RST_MAIN 8'h00
`define IEG_EXT_B_MASK 8'h07
`define IEG_GLOBAL_BIT 7
`define IEG_NUM_SRC 18
`define IEG_NUM_FLAGS 30

`endif

//--- ieg_pkg.sv
// types shared by the interrupt enable gating stage
// assumes ieg_params.svh is on the include path
package ieg_pkg;
`include "ieg_params.svh"
    typedef logic [`IEG_NUM_SRC-1:0] ieg_src_t;
    typedef logic [`IEG_NUM_FLAGS-1:0] ieg_flags_t;
    typedef enum logic [1:0] {IEG_ST_ADDR, IEG_ST_WRITE, IEG_ST_READ} ieg_phase_e;
endpackage

//--- ieg_gate_if.sv
// carrier between the register front end and the gating core
// assumes both ends run on one clock
`timescale 1ns/1ps
`default_nettype none
interface ieg_gate_if;
    logic [7:0] enable_main;
    logic [7:0] enable_ext_a;
    logic [7:0] enable_ext_b;
    ieg_pkg::ieg_flags_t flags;
    ieg_pkg::ieg_src_t request;
    logic any_request;
    modport core (input enable_main, input enable_ext_a, input enable_ext_b, input flags,
        output request, output any_request);
    modport regs (output enable_main, output enable_ext_a, output enable_ext_b, output flags,
        input request, input any_request);
endinterface
`default_nettype wire

//--- ieg_gate_core.sv
// gating core: flags are grouped per source and masked by individual and global enables
// assumes flags and enables are registered in the front end
`timescale 1ns/1ps
`default_nettype none
`include "ieg_params.svh"
module ieg_gate_core (
    ieg_gate_if.core gate
);
    // ****************************************
    // flag grouping into sources
    // ****************************************
    // flag order: 0 ext0, 1 timer0, 2 ext1, 3 timer1, 4 uart0 tx, 5 uart0 rx, 6 brownout,
    // 7 adc, 8 i2c status, 9 i2c timeout, 10 pin change, 11 pwm, 12-14 capture, 15 watchdog,
    // 16 brake, 17 spi done, 18 spi overrun, 19 spi mode fault, 20 timer2, 21 uart1 tx,
    // 22 uart1 rx, 23 timer3, 24 wake timer, 25-29 spare
    wire [`IEG_NUM_FLAGS-1:0] f = gate.flags;
    wire [`IEG_NUM_SRC-1:0] src_pending;
    wire [`IEG_NUM_SRC-1:0] src_enable;
    assign src_pending = {f[24], f[23], f[21] | f[22],
        f[20], f[17] | f[18] | f[19], f[16], f[15], f[11], |f[14:12], f[10], f[8] | f[9],
        f[7], f[6], f[4] | f[5], f[3], f[2], f[1], f[0]} ;
    // source index equals enable bit position: main 0..6, ext a 7..14, ext b 15..17
    assign src_enable = {gate.enable_ext_b[2:0], gate.enable_ext_a[7:0],
        gate.enable_main[6:0]};
    // flags stay set in the front end, so a masked source simply waits here
    wire global_on = gate.enable_main[`IEG_GLOBAL_BIT];
    assign gate.request = global_on ? (src_pending & src_enable) : '0;
    assign gate.any_request = |gate.request;
endmodule
`default_nettype wire

//--- ieg_top.sv
// ahb-lite register front end for the interrupt enable gating stage
// assumes a single ahb-lite master; peripherals give one-cycle set pulses for their flags
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "ieg_params.svh"
module ieg_top #(
    parameter int NUM_FLAGS = `IEG_NUM_FLAGS
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic [NUM_FLAGS-1:0] FLAG_SET_I,
    input wire logic [NUM_FLAGS-1:0] FLAG_CLR_I,
    output logic [`IEG_NUM_SRC-1:0] IRQ_REQ_O,
    output logic IRQ_ANY_O
);
    // ****************************************
    // state
    // ****************************************
    ieg_gate_if gate ();
    logic [7:0] enable_main;
    logic [7:0] enable_ext_a;
    logic [7:0] enable_ext_b;
    logic [NUM_FLAGS-1:0] flags;
    logic [7:0] wr_addr;
    ieg_pkg::ieg_phase_e phase;
    logic [31:0] rdata;

    // ****************************************
    // ahb address phase decode
    // ****************************************
    wire take = HSEL_I & HREADY_I & HTRANS_I[1];
    // registers sit one to an aligned word, so the index is the word address
    wire [7:0] a_addr = HADDR_I[9:2];
    wire hit_high = (HADDR_I[31:10] == 22'h000000) & (HADDR_I[1:0] == 2'b00);

    function automatic logic [31:0] read_mux(input logic [7:0] addr, input logic ok);
        logic [31:0] v;
        v = 32'h00000000;
        if (ok) begin
            case (addr)
                `IEG_IDX_MAIN: v = {24'h000000, enable_main};
                `IEG_IDX_EXT_A: v = {24'h000000, enable_ext_a};
                `IEG_IDX_EXT_B: v = {24'h000000, enable_ext_b & `IEG_EXT_B_MASK};
                `IEG_IDX_FLAG_LO: v = 32'(flags);
                `IEG_IDX_REQ: v = 32'(gate.request);
                default: v = 32'h00000000;
            endcase
        end
        return v;
    endfunction

    // ****************************************
    // data phase: write in the cycle after the address phase, zero wait states
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            phase <= ieg_pkg::IEG_ST_ADDR;
            wr_addr <= 8'h00;
            rdata <= 32'h00000000;
        end else begin
            wr_addr <= a_addr;
            rdata <= read_mux(a_addr, hit_high);
            // writes outside the map must not alias onto the low registers
            case ({take & hit_high, HWRITE_I})
                2'b11: phase <= ieg_pkg::IEG_ST_WRITE;
                2'b10: phase <= ieg_pkg::IEG_ST_READ;
                default: phase <= ieg_pkg::IEG_ST_ADDR;
            endcase
        end
    end

    wire wr_now = (phase == ieg_pkg::IEG_ST_WRITE);
    wire [7:0] wbyte = HWDATA_I[7:0];
    wire wr_main = wr_now & (wr_addr == `IEG_IDX_MAIN);
    wire wr_ext_a = wr_now & (wr_addr == `IEG_IDX_EXT_A);
    wire wr_ext_b = wr_now & (wr_addr == `IEG_IDX_EXT_B);
    wire wr_flag = wr_now & (wr_addr == `IEG_IDX_FLAG_LO);

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            enable_main <= `IEG_RST_MAIN;
            enable_ext_a <= `IEG_RST_EXT_A;
            enable_ext_b <= `IEG_RST_EXT_B;
        end else begin
            if (wr_main) begin
                enable_main <= wbyte;
            end
            if (wr_ext_a) begin
                enable_ext_a <= wbyte;
            end
            if (wr_ext_b) begin
                enable_ext_b <= wbyte & `IEG_EXT_B_MASK;
            end
        end
    end

    // ****************************************
    // flags: software writes the whole vector; hardware set beats any clear
    // ****************************************
    // software write 1 sets and write 0 clears, so a self-triggered interrupt is one store
    wire [NUM_FLAGS-1:0] sw_val = NUM_FLAGS'(HWDATA_I);
    wire [NUM_FLAGS-1:0] next_flags = wr_flag
        ? (sw_val | FLAG_SET_I)
        : ((flags & ~FLAG_CLR_I) | FLAG_SET_I);

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // ****************************************
    // core and outputs
    // ****************************************
    assign gate.enable_main = enable_main;
    assign gate.enable_ext_a = enable_ext_a;
    assign gate.enable_ext_b = enable_ext_b;
    assign gate.flags = `IEG_NUM_FLAGS'(flags);

    ieg_gate_core u_core (
        .gate(gate)
    );

    assign IRQ_REQ_O = gate.request;
    assign IRQ_ANY_O = gate.any_request;
    assign HRDATA_O = rdata;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
endmodule
`default_nettype wire

//--- ieg_chk_sva.sv
// port checker for the interrupt enable gating stage
// assumes it is bound to ieg_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
`include "ieg_params.svh"
module ieg_chk #(
    parameter int NUM_FLAGS = 30
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic [NUM_FLAGS-1:0] FLAG_SET_I,
    input wire logic [NUM_FLAGS-1:0] FLAG_CLR_I,
    input wire logic [`IEG_NUM_SRC-1:0] IRQ_REQ_O,
    input wire logic IRQ_ANY_O
);
    // ****************
    // data phase tracking
    // ****************
    logic take, wr_q, rd_q;
    logic [7:0] a_q;
    assign take = HSEL_I && HREADY_I && HTRANS_I[1];
    always_ff @(posedge CLK_I) begin
        wr_q <= !SYS_RST_I && take && HWRITE_I;
        rd_q <= !SYS_RST_I && take && !HWRITE_I;
        a_q <= HADDR_I[9:2];
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    a_any_or: assert property (IRQ_ANY_O == |IRQ_REQ_O)
        else $error("any request differs from or of requests");
    a_ready_high: assert property (HREADYOUT_O)
        else $error("ready output low");
    a_resp_okay: assert property (!HRESP_O)
        else $error("response not okay");
    // requests only move on a flag or register event, so pending ones are held
    a_req_cause: assert property ($changed(IRQ_REQ_O)
        |-> $past(wr_q || (|FLAG_CLR_I) || (|FLAG_SET_I)))
        else $error("request changed without cause");
    a_rise_set: assert property ($rose(IRQ_REQ_O[0]) |-> $past(FLAG_SET_I[0] || wr_q))
        else $error("request rose without a flag set");
    a_clr_drops: assert property (FLAG_CLR_I[0] && !FLAG_SET_I[0] && !wr_q |=> !IRQ_REQ_O[0])
        else $error("cleared flag still requests");
    a_ext_b_mask: assert property (rd_q && a_q == 8'h9c |-> HRDATA_O[31:3] == 29'h0)
        else $error("unused ext b bits read nonzero");
    a_reg_width: assert property (rd_q && (a_q == 8'ha8 || a_q == 8'hb4)
        |-> HRDATA_O[31:8] == 24'h0)
        else $error("byte register read wide data");
endmodule
`default_nettype wire

//--- ieg_flag_src.sv
// peripheral flag source model: one-cycle set and clear pulses per flag
// assumes the bench fires it just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ieg_flag_src #(
    parameter int NUM_FLAGS = 30
) (
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic clear_i,
    input wire logic [4:0] idx_i,
    output logic [NUM_FLAGS-1:0] set_o,
    output logic [NUM_FLAGS-1:0] clr_o
);
    // pulses, not levels, so a stuck flag in the design cannot hide behind a held input
    always_ff @(posedge clk_i) begin
        set_o <= fire_i ? NUM_FLAGS'(1) << idx_i : '0;
        clr_o <= clear_i ? NUM_FLAGS'(1) << idx_i : '0;
    end
endmodule
`default_nettype wire

//--- ieg_tb.sv
// self-checking bench for ieg_top over ahb-lite with a flag source model
// assumes zero wait states are not relied on; waits follow hreadyout
`timescale 1ns/1ps
`default_nettype none
`include "ieg_params.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
    logic clk, rst = 1, hsel = 0, hwrite = 0, fire = 0, clear = 0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = '0, hwdata = '0, d;
    logic [4:0] idx = '0;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, irq_any;
    wire logic [29:0] fset, fclr;
    wire logic [`IEG_NUM_SRC-1:0] irq;
    int failures = 0, n_tests = 0, cycles = 0;
    // rows: register, enable value, flag index, request index
    logic [31:0] rows [25] = '{32'ha8810000, 32'ha8820101, 32'ha8840202, 32'ha8880303,
        32'ha8900404, 32'ha8900504, 32'ha8a00605, 32'ha8c00706, 32'h9b010807, 32'h9b010907,
        32'h9b020a08, 32'h9b080b0a, 32'h9b040c09, 32'h9b040d09, 32'h9b040e09, 32'h9b100f0b,
        32'h9b20100c, 32'h9b40110d, 32'h9b40120d, 32'h9b40130d, 32'h9b80140e, 32'h9c01150f,
        32'h9c01160f, 32'h9c021710, 32'h9c041811};
    ieg_top dut_u (.CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .FLAG_SET_I(fset), .FLAG_CLR_I(fclr), .IRQ_REQ_O(irq), .IRQ_ANY_O(irq_any));
    ieg_flag_src src_u (.clk_i(clk), .fire_i(fire), .clear_i(clear), .idx_i(idx),
        .set_o(fset), .clr_o(fclr));
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        // a is the register index; the bus carries four times it as the byte address
        hsel <= 1; htrans <= 2'h2; haddr <= {22'h0, a, 2'b00}; hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        d = hrdata;
    endtask
    task automatic pulse(input logic [4:0] i, input logic c);
        fire <= !c; clear <= c; idx <= i;
        @(posedge clk);
        fire <= 0; clear <= 0;
        @(posedge clk);
        @(negedge clk);
        @(posedge clk);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        foreach (rows[i]) begin
            bus(0, rows[i][31:24], 0); `CHK(d, 32'h0)
        end
        foreach (rows[i]) begin
            if (rows[i][31:24] != 8'ha8) bus(1, 8'ha8, 32'h80);
            bus(1, rows[i][31:24], {24'h0, rows[i][23:16]});
            pulse(rows[i][12:8], 0); `CHK(irq, 18'(1) << rows[i][4:0])
            pulse(rows[i][12:8], 1); `CHK(irq, 18'h0)
        end
        bus(1, 8'h9b, 0); bus(1, 8'h9c, 0); bus(1, 8'ha8, 32'h80);
        pulse(1, 0); `CHK(irq, 18'h0)
        bus(1, 8'ha8, 32'h03); @(posedge clk); `CHK(irq, 18'h0)
        pulse(0, 0); `CHK(irq, 18'h0)
        bus(1, 8'ha8, 32'h83); @(posedge clk); `CHK(irq, 18'h3)
        bus(1, 8'hb0, 0); @(posedge clk); `CHK(irq, 18'h0)
        bus(1, 8'hb0, 32'h2); @(posedge clk); `CHK(irq_any, 1'b1)
        bus(0, 8'hb8, 0); `CHK(d, 32'h2)
        bus(0, 8'hb0, 0); `CHK(d, 32'h2)
        bus(1, 8'h9c, 32'hff); bus(0, 8'h9c, 0); `CHK(d, 32'h7)
        bus(0, 8'hb4, 0); `CHK(d, 32'h0)
        rst <= 1;
        repeat (3) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        `CHK(irq, 18'h0)
        bus(0, 8'ha8, 0); `CHK(d, 32'h0)
        tally_and_finish();
    end
endmodule
bind ieg_top ieg_chk #(.NUM_FLAGS(NUM_FLAGS)) chk_u (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
    .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .FLAG_SET_I(FLAG_SET_I), .FLAG_CLR_I(FLAG_CLR_I), .IRQ_REQ_O(IRQ_REQ_O), .IRQ_ANY_O(IRQ_ANY_O));
`default_nettype wire
